// ### rtl/lsb_blink_seq.sv
`timescale 1ns/1ps
module lsb_blink_seq
  import lsb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sink_enable,
  input wire logic blink_off_en,
  input wire logic [CNT_W-1:0] on_cycles,
  input wire logic [CNT_W-1:0] off_cycles,
  output logic sink_on
);
  lsb_blink_state_t state;
  lsb_blink_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic enable_q;

  always_comb begin
    next_state = state;
    next_cnt = cnt + CNT_W'(1);
    if (!sink_enable) begin
      next_state = BLK_IDLE; // R13
      next_cnt = '0;
    end else if (!enable_q) begin
      // every sink of one write sees its rising edge on the same cycle
      next_state = BLK_ON; // R11 R13
      next_cnt = '0;
    end else begin
      unique case (state)
        BLK_IDLE: begin
          next_state = BLK_ON;
          next_cnt = '0;
        end
        BLK_ON: begin
          if (!blink_off_en) begin
            next_cnt = '0; // R07
          end else if (cnt >= on_cycles - CNT_W'(1)) begin
            next_state = BLK_OFF; // R06
            next_cnt = '0;
          end
        end
        BLK_OFF: begin
          if (!blink_off_en || cnt >= off_cycles - CNT_W'(1)) begin
            next_state = BLK_ON; // R08
            next_cnt = '0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= BLK_IDLE;
      cnt <= '0;
      enable_q <= 1'b0;
      sink_on <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      enable_q <= sink_enable;
      sink_on <= (next_state == BLK_ON); // R06 R07 R08
    end
  end
endmodule // lsb_blink_seq

// ### rtl/lsb_pkg.sv
package lsb_pkg;
  localparam int SINK_COUNT = 7;
  localparam int CNT_W = 32;

  // register addresses
  localparam logic [7:0] ADDR_SINK_FADE_LAW_CTRL = 8'h0f;
  localparam logic [7:0] ADDR_SINK_ENABLE_CTRL = 8'h10;
  localparam logic [7:0] ADDR_SINK_BLINK_TIME_A = 8'h11;

  // field positions
  localparam int FADE_LAW_LSB = 0;
  localparam int FADE_LAW_W = 2;
  localparam int ENABLE_LSB = 0;
  localparam int ON_TIME_LSB = 6;
  localparam int SINK5_OFF_LSB = 0;
  localparam int SINK6_OFF_LSB = 2;
  localparam int SINK7_OFF_LSB = 4;
  localparam int FIRST_TIMED_SINK = 4;

  // reset values
  localparam logic [1:0] FADE_LAW_RESET = 2'h0;
  localparam logic [6:0] ENABLE_RESET = 7'h00;
  localparam logic [7:0] BLINK_TIME_RESET = 8'h00;

  // timing, clock 25 MHz
  localparam int CLK_HZ = 25_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int ON_MS_00 = 200;
  localparam int ON_MS_01 = 600;
  localparam int ON_MS_10 = 800;
  localparam int ON_MS_11 = 1200;
  localparam int OFF_MS_01 = 600;
  localparam int OFF_MS_10 = 1200;
  localparam int OFF_MS_11 = 1800;

  typedef enum logic [1:0] {
    LAW_LINEAR = 2'h0,
    LAW_SQUARE = 2'h1,
    LAW_CUBIC_10 = 2'h2,
    LAW_CUBIC_11 = 2'h3
  } lsb_law_t;

  typedef enum logic [2:0] {
    BLK_IDLE = 3'h1,
    BLK_ON = 3'h2,
    BLK_OFF = 3'h4
  } lsb_blink_state_t;

  function automatic logic [CNT_W-1:0] lsb_on_ms(input logic [1:0] code);
    unique case (code)
      2'h0: lsb_on_ms = CNT_W'(ON_MS_00);
      2'h1: lsb_on_ms = CNT_W'(ON_MS_01);
      2'h2: lsb_on_ms = CNT_W'(ON_MS_10);
      2'h3: lsb_on_ms = CNT_W'(ON_MS_11);
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] lsb_off_ms(input logic [1:0] code);
    unique case (code)
      2'h0: lsb_off_ms = '0;
      2'h1: lsb_off_ms = CNT_W'(OFF_MS_01);
      2'h2: lsb_off_ms = CNT_W'(OFF_MS_10);
      2'h3: lsb_off_ms = CNT_W'(OFF_MS_11);
    endcase
  endfunction
endpackage

// ### rtl/lsb_sink_ctrl.sv
// Behaviour
// R01 - fade law bits 1:0, 7:2 reserved
// R02 - 00 linear DAC, 01 square; linear steps
// R03 - 10, 11 square DAC, two cubic profiles
// R04 - enable bit n drives sink n+1
// R05 - on time 0.2/0.6/0.8/1.2 s in 7:6
// R06 - timed sink stays on, then off
// R07 - off code 00 keeps sink on
// R08 - off period then on again, repeating
// R09 - off codes 0.6/1.2/1.8 s
// R10 - sink 7/6/5 off fields at 5:4/3:2/1:0
// R11 - sinks enabled together blink in step
// R12 - fade law register at 0x0f
// R13 - enable rise restarts timer, clear stops
`timescale 1ns/1ps
module lsb_sink_ctrl
  import lsb_pkg::*;
#(
  parameter int CYCLES_PER_MS = CYC_PER_MS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [SINK_COUNT-1:0] sink_on,
  output logic [1:0] sink_fade_law,
  output logic fade_square_law,
  output logic fade_cubic_steps,
  output logic fade_cubic_profile
);
  logic [1:0] fade_law;
  logic [SINK_COUNT-1:0] sink_enable;
  logic [7:0] blink_time;
  logic [CNT_W-1:0] on_cycles;
  logic [1:0] off_code [SINK_COUNT];
  logic [SINK_COUNT-1:0] seq_on;
  logic [7:0] next_rdata;

  // register writes; reserved bits are not stored
  always_ff @(posedge clk) begin
    if (rst) begin
      fade_law <= FADE_LAW_RESET;
    end else if (reg_wr && reg_addr == ADDR_SINK_FADE_LAW_CTRL) begin // R12
      fade_law <= reg_wdata[FADE_LAW_LSB +: FADE_LAW_W]; // R01
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sink_enable <= ENABLE_RESET;
    end else if (reg_wr && reg_addr == ADDR_SINK_ENABLE_CTRL) begin
      // all bits land in one cycle so sinks of one write start together
      sink_enable <= reg_wdata[ENABLE_LSB +: SINK_COUNT]; // R04 R11
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      blink_time <= BLINK_TIME_RESET;
    end else if (reg_wr && reg_addr == ADDR_SINK_BLINK_TIME_A) begin
      blink_time <= reg_wdata;
    end
  end

  // read path; reserved bits and unmapped addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    if (reg_addr == ADDR_SINK_FADE_LAW_CTRL) begin
      next_rdata = {6'h00, fade_law}; // R01
    end else if (reg_addr == ADDR_SINK_ENABLE_CTRL) begin
      next_rdata = {1'b0, sink_enable}; // R04
    end else if (reg_addr == ADDR_SINK_BLINK_TIME_A) begin
      next_rdata = blink_time;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // fade law decode for the current DACs and step generator
  always_ff @(posedge clk) begin
    if (rst) begin
      sink_fade_law <= FADE_LAW_RESET;
      fade_square_law <= 1'b0;
      fade_cubic_steps <= 1'b0;
      fade_cubic_profile <= 1'b0;
    end else begin
      sink_fade_law <= fade_law;
      fade_square_law <= (fade_law != LAW_LINEAR); // R02 R03
      fade_cubic_steps <= (fade_law == LAW_CUBIC_10) || (fade_law == LAW_CUBIC_11); // R03
      fade_cubic_profile <= (fade_law == LAW_CUBIC_11); // R03
    end
  end

  // shared on time; a product in cycles, not a prescaled tick, keeps alignment exact
  always_comb begin
    on_cycles = CNT_W'(lsb_on_ms(blink_time[ON_TIME_LSB +: 2]) * CNT_W'(CYCLES_PER_MS)); // R05
  end

  genvar i;
  generate
    for (i = 0; i < SINK_COUNT; i++) begin : g_sink
      logic [CNT_W-1:0] off_cycles;
      // sinks 1 to 4 have their off times elsewhere; held at 00 here
      if (i == FIRST_TIMED_SINK) begin : g_s5
        assign off_code[i] = blink_time[SINK5_OFF_LSB +: 2]; // R10
      end else if (i == FIRST_TIMED_SINK + 1) begin : g_s6
        assign off_code[i] = blink_time[SINK6_OFF_LSB +: 2]; // R10
      end else if (i == FIRST_TIMED_SINK + 2) begin : g_s7
        assign off_code[i] = blink_time[SINK7_OFF_LSB +: 2]; // R10
      end else begin : g_fixed
        assign off_code[i] = 2'h0;
      end
      assign off_cycles = CNT_W'(lsb_off_ms(off_code[i]) * CNT_W'(CYCLES_PER_MS)); // R09
      lsb_blink_seq u_seq (
        .clk(clk),
        .rst(rst),
        .sink_enable(sink_enable[i]),
        .blink_off_en(off_code[i] != 2'h0), // R07
        .on_cycles(on_cycles),
        .off_cycles(off_cycles),
        .sink_on(seq_on[i])
      );
    end
  endgenerate

  always_comb begin
    sink_on = seq_on;
  end
endmodule // lsb_sink_ctrl

// ### verification/lsb_sink_ctrl_checker.sv
`timescale 1ns/1ps
module lsb_sink_ctrl_checker
  import lsb_pkg::*;
#(parameter int CYCLES_PER_MS = CYC_PER_MS) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [SINK_COUNT-1:0] sink_on,
  input wire logic [1:0] sink_fade_law,
  input wire logic fade_square_law,
  input wire logic fade_cubic_steps,
  input wire logic fade_cubic_profile
);
  int on_run;
  int off_run;
  always_ff @(posedge clk) on_run <= sink_on[4] ? on_run + 1 : 0;
  always_ff @(posedge clk) off_run <= sink_on[4] ? 0 : off_run + 1;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_en_wr; reg_wr && reg_addr == ADDR_SINK_ENABLE_CTRL; endsequence
  sequence s_law_wr; reg_wr && reg_addr == ADDR_SINK_FADE_LAW_CTRL; endsequence
  a_law_square: assert property (fade_square_law == (sink_fade_law != 2'h0)) else $error("square flag");
  a_law_cubic: assert property (fade_cubic_steps == sink_fade_law[1]) else $error("cubic flag");
  a_law_profile: assert property (fade_cubic_profile == (sink_fade_law == 2'h3)) else $error("profile");
  a_law_store: assert property (s_law_wr ##1 !reg_wr |-> ##1 sink_fade_law == $past(reg_wdata[1:0], 2))
    else $error("law store");
  a_rsvd_read: assert property (reg_rd && reg_addr == ADDR_SINK_FADE_LAW_CTRL |=> reg_rdata[7:2] == 6'h00)
    else $error("reserved bits");
  a_enable_map: assert property (s_en_wr |-> ##2 sink_on[3:0] == $past(reg_wdata[3:0], 2))
    else $error("enable map");
  a_clear_off: assert property (s_en_wr ##0 !reg_wdata[4] |-> ##2 !sink_on[4]) else $error("clear");
  // a write two cycles back may cut a period short on purpose
  a_on_min: assert property ($fell(sink_on[4]) && !$past(reg_wr, 2) |->
    on_run >= ON_MS_00 * CYCLES_PER_MS) else $error("on too short");
  a_off_min: assert property ($rose(sink_on[4]) && !$past(reg_wr, 2) |->
    off_run >= OFF_MS_01 * CYCLES_PER_MS) else $error("off too short");
endmodule // lsb_sink_ctrl_checker
bind lsb_sink_ctrl lsb_sink_ctrl_checker #(.CYCLES_PER_MS(CYCLES_PER_MS)) chk_i (.clk(clk), .rst(rst),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .sink_on(sink_on), .sink_fade_law(sink_fade_law), .fade_square_law(fade_square_law),
  .fade_cubic_steps(fade_cubic_steps), .fade_cubic_profile(fade_cubic_profile));

// ### verification/lsb_sink_ctrl_tb_top.sv
`timescale 1ns/1ps
module lsb_sink_ctrl_tb_top
  import lsb_pkg::*;
;
  localparam int CPM = 2;
  logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [6:0] sink_on;
  logic [1:0] sink_fade_law;
  logic fade_square_law, fade_cubic_steps, fade_cubic_profile;
  int n_errors = 0, cmp_count = 0, cycles = 0;
  int on_ms[4] = '{ON_MS_00, ON_MS_01, ON_MS_10, ON_MS_11};
  lsb_sink_ctrl #(.CYCLES_PER_MS(CPM)) uut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sink_on(sink_on),
    .sink_fade_law(sink_fade_law), .fade_square_law(fade_square_law), .fade_cubic_steps(fade_cubic_steps),
    .fade_cubic_profile(fade_cubic_profile));
  initial forever #20 clk = ~clk;
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // run needs about 10k cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // each access starts on a fresh edge so strobes never toggle twice in a step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic at(input int n, input logic [7:0] exp);
    repeat (n) @(posedge clk);
    #1 chk({1'b0, sink_on}, exp);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(8'h0f, 8'h00);
    rd(8'h10, 8'h00);
    rd(8'h11, 8'h00);
    rd(8'h20, 8'h00);
    $display("test reset done");
    for (int c = 0; c < 4; c++) begin
      wr(8'h0f, 8'hfc | 8'(c));
      rd(8'h0f, 8'(c));
      chk({6'h00, sink_fade_law}, 8'(c));
      chk({5'h00, fade_square_law, fade_cubic_steps, fade_cubic_profile}, {5'h00, c != 0, c > 1, c == 3});
    end
    $display("test fade law done");
    wr(8'h10, 8'hff);
    at(2, 8'h7f);
    rd(8'h10, 8'h7f);
    wr(8'h10, 8'h00);
    $display("test enable done");
    for (int c = 0; c < 4; c++) begin
      wr(8'h11, {2'(c), 6'h01});
      wr(8'h10, 8'h10);
      at(on_ms[c] * CPM, 8'h10);
      at(1, 8'h00);
      wr(8'h10, 8'h00);
    end
    $display("test on time done");
    wr(8'h11, 8'h39);
    rd(8'h11, 8'h39);
    wr(8'h10, 8'h70);
    at(2, 8'h70);
    at(ON_MS_00 * CPM, 8'h00);
    at(OFF_MS_01 * CPM, 8'h10);
    at(OFF_MS_01 * CPM, 8'h20);
    at(OFF_MS_01 * CPM, 8'h40);
    wr(8'h10, 8'h00);
    at(2, 8'h00);
    $display("test blink done");
    report_and_stop();
  end
endmodule // lsb_sink_ctrl_tb_top
